// ---- design/rsseq_top.sv ----
// Reset and start-up sequencer with dual-speed clock control
`timescale 1ns/1ns
// Summary of operation
// - Software switches internal clock modes to slow rate
// - One select bit picks normal or slow rate
// - Slow rate fixed, independent of external resistor
// - Fast to slow stalls core 100-300 us
// - Slow to fast stalls core 1.25-3.25 us
// - Power-up and non-power-up reset classes
// - Watchdog in sleep wakes, keeps all registers but the cause register
// - External pin filter ignores short low pulses
// - Watchdog reset never drives the pin low
// - Supply-rise detection makes a power-on pulse
// - Power-up delay only on power-up resets, holds reset
// - Delay starts at pulse or supply recovery
// - Delay enable affects power-on only; drops always delay
// - Power-up delay counts its own RC ticks
// - Oscillator count 1024 input cycles after delay
// - Oscillator count: crystal modes, power-up or wake
// - Two-bit trip select plus drop reset enable
// - Reset only on dips longer than minimum duration
// - Hold until recovery; new dip restarts delay
// - RC mode, delay disabled: no power-on time-out
// - Time-outs run under held pin; release starts immediately
// - Delay enable bit active low
// - Power-on flag cleared only by power-on reset or a software write
// - Drop flag set by power-on, cleared by drop
module rsseq_top #(
  parameter int DELAY_TICKS = rsseq_pkg::DELAY_TICKS,
  parameter int OST_CYCLES = rsseq_pkg::OST_CYCLES,
  parameter int DROP_MIN_CYCLES = rsseq_pkg::DROP_MIN_CYCLES,
  parameter int PIN_FILTER_CYCLES = rsseq_pkg::PIN_FILTER_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [rsseq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rsseq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rsseq_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_por_detect,
  input wire logic i_supply_below_trip,
  input wire logic i_ext_reset_pin,
  input wire logic i_wdt_timeout,
  input wire logic i_sleep,
  input wire logic i_rc_tick,
  input wire logic i_osc_tick,
  output logic o_core_reset,
  output logic o_core_stall,
  output logic o_wake,
  output logic o_slow_clock,
  output rsseq_pkg::rsseq_drop_ctl_s o_drop_ctl,
  output logic o_ext_pin_oe_n
);

  localparam int DW = $clog2(DELAY_TICKS + 1);
  localparam int OW = $clog2(OST_CYCLES + 1);

  if (DELAY_TICKS < 1 || OST_CYCLES < 1) begin : g_chk_cnt
    $error("Delay and oscillator counts must be at least 1");
  end
  if (rsseq_pkg::F2S_MAX_CYCLES >= 2 ** rsseq_pkg::STALL_W) begin : g_chk_stall
    $error("Stall counter too narrow");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic por_lvl;
  logic drop_lvl;
  logic pin_lvl;
  logic por_prev_reg;
  logic por_pulse;

  rsseq_sync_filter #(.FILTER_CYCLES(1), .RESET_LEVEL(1'b0)) u_sync_por (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_por_detect),
    .o_level(por_lvl)
  );

  // Dips shorter than the minimum never reach the state machine
  rsseq_sync_filter #(.FILTER_CYCLES(DROP_MIN_CYCLES), .RESET_LEVEL(1'b0)) u_sync_drop (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_supply_below_trip),
    .o_level(drop_lvl)
  );

  rsseq_sync_filter #(.FILTER_CYCLES(PIN_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_sync_pin (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_ext_reset_pin),
    .o_level(pin_lvl)
  );

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      por_prev_reg <= 1'b0;
    end else begin
      por_prev_reg <= por_lvl;
    end
  end

  assign por_pulse = por_lvl & ~por_prev_reg;

  // ----------------------------------------------------------------
  // Configuration and status registers
  // ----------------------------------------------------------------
  rsseq_pkg::rsseq_cfg_s cfg_reg;
  logic drop_flag_reg;
  logic por_flag_reg;
  logic fast_sel_reg;
  logic crystal;
  logic dual_speed;
  logic drop_trip;
  rsseq_pkg::rsseq_state_e state_reg;
  rsseq_pkg::rsseq_state_e state_next;
  rsseq_pkg::rsseq_cause_e cause_reg;
  rsseq_pkg::rsseq_cause_e cause_next;
  logic wake_next;
  logic drop_entry;
  logic np_reset;
  logic pcs_wr;

  assign crystal = cfg_reg.osc_mode < rsseq_pkg::MODE_EC;
  assign dual_speed = cfg_reg.osc_mode[rsseq_pkg::MODE_RC_BIT];
  assign drop_trip = cfg_reg.drop_en & drop_lvl;
  assign drop_entry = (state_next == rsseq_pkg::S_DROP) && (state_reg != rsseq_pkg::S_DROP);
  assign np_reset = (state_next == rsseq_pkg::S_HOLD)
                    && (state_reg == rsseq_pkg::S_RUN || state_reg == rsseq_pkg::S_WAKE);
  assign pcs_wr = i_wr && (i_addr == rsseq_pkg::ADDR_PCS);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_reg <= rsseq_pkg::CFG_RESET;
    end else if (i_wr && i_addr == rsseq_pkg::ADDR_CFG) begin
      cfg_reg <= i_wdata;
    end
  end

  // Hardware events win over a software write in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drop_flag_reg <= rsseq_pkg::PCS_RESET[rsseq_pkg::PCS_DROP_BIT];
      por_flag_reg <= rsseq_pkg::PCS_RESET[rsseq_pkg::PCS_POR_BIT];
      fast_sel_reg <= rsseq_pkg::PCS_RESET[rsseq_pkg::PCS_FAST_BIT];
    end else if (por_pulse) begin
      por_flag_reg <= 1'b0;
      drop_flag_reg <= 1'b1;
      fast_sel_reg <= 1'b1;
    end else if (drop_entry) begin
      drop_flag_reg <= 1'b0;
      fast_sel_reg <= 1'b1;
    end else if (np_reset) begin
      fast_sel_reg <= 1'b1;
    end else if (pcs_wr) begin
      drop_flag_reg <= i_wdata[rsseq_pkg::PCS_DROP_BIT];
      por_flag_reg <= i_wdata[rsseq_pkg::PCS_POR_BIT];
      fast_sel_reg <= i_wdata[rsseq_pkg::PCS_FAST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  logic [DW-1:0] delay_cnt_reg;
  logic [OW-1:0] ost_cnt_reg;
  logic delay_done;
  logic ost_done;

  assign delay_done = i_rc_tick && (delay_cnt_reg == DW'(DELAY_TICKS - 1));
  assign ost_done = i_osc_tick && (ost_cnt_reg == OW'(OST_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    wake_next = 1'b0;
    if (por_pulse) begin
      // Pin level is ignored here: time-outs run even with the pin held
      cause_next = rsseq_pkg::CAUSE_POR;
      if (!cfg_reg.delay_en_n) begin
        state_next = rsseq_pkg::S_DELAY;
      end else if (crystal) begin
        state_next = rsseq_pkg::S_OSC;
      end else begin
        state_next = rsseq_pkg::S_HOLD;
      end
    end else if (drop_trip) begin
      state_next = rsseq_pkg::S_DROP;
      cause_next = rsseq_pkg::CAUSE_DROP;
    end else begin
      unique case (state_reg)
        rsseq_pkg::S_OFF: begin
        end
        rsseq_pkg::S_DROP: begin
          state_next = rsseq_pkg::S_DELAY;
        end
        rsseq_pkg::S_DELAY: begin
          if (delay_done) begin
            state_next = crystal ? rsseq_pkg::S_OSC : rsseq_pkg::S_HOLD;
          end
        end
        rsseq_pkg::S_OSC: begin
          if (ost_done) begin
            state_next = rsseq_pkg::S_HOLD;
          end
        end
        rsseq_pkg::S_HOLD: begin
          if (pin_lvl) begin
            state_next = rsseq_pkg::S_RUN;
          end
        end
        rsseq_pkg::S_RUN: begin
          if (!pin_lvl) begin
            state_next = rsseq_pkg::S_HOLD;
            cause_next = i_sleep ? rsseq_pkg::CAUSE_PIN_SLEEP : rsseq_pkg::CAUSE_PIN_RUN;
          end else if (i_wdt_timeout && i_sleep) begin
            cause_next = rsseq_pkg::CAUSE_WDT_WAKE;
            if (crystal) begin
              state_next = rsseq_pkg::S_WAKE;
            end else begin
              wake_next = 1'b1;
            end
          end else if (i_wdt_timeout) begin
            state_next = rsseq_pkg::S_HOLD;
            cause_next = rsseq_pkg::CAUSE_WDT;
          end
        end
        rsseq_pkg::S_WAKE: begin
          if (!pin_lvl) begin
            state_next = rsseq_pkg::S_HOLD;
            cause_next = rsseq_pkg::CAUSE_PIN_SLEEP;
          end else if (ost_done) begin
            state_next = rsseq_pkg::S_RUN;
            wake_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= rsseq_pkg::S_OFF;
      cause_reg <= rsseq_pkg::CAUSE_NONE;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  // Counts ticks of the delay RC oscillator, never the core clock
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      delay_cnt_reg <= '0;
    end else if (state_reg != rsseq_pkg::S_DELAY || por_pulse || drop_trip) begin
      delay_cnt_reg <= '0;
    end else if (i_rc_tick) begin
      delay_cnt_reg <= delay_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ost_cnt_reg <= '0;
    end else if ((state_reg != rsseq_pkg::S_OSC && state_reg != rsseq_pkg::S_WAKE) || por_pulse) begin
      ost_cnt_reg <= '0;
    end else if (i_osc_tick) begin
      ost_cnt_reg <= ost_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Reset, wake and pin outputs
  // ----------------------------------------------------------------
  logic core_reset_reg;
  logic wake_reg;
  logic pin_oe_n_reg;
  rsseq_pkg::rsseq_drop_ctl_s drop_ctl_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_reset_reg <= 1'b1;
      wake_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      drop_ctl_reg <= '0;
    end else begin
      core_reset_reg <= !(state_next == rsseq_pkg::S_RUN || state_next == rsseq_pkg::S_WAKE);
      wake_reg <= wake_next;
      pin_oe_n_reg <= 1'b1;
      drop_ctl_reg <= {cfg_reg.drop_en, cfg_reg.trip_sel};
    end
  end

  // ----------------------------------------------------------------
  // Dual-speed clock control
  // ----------------------------------------------------------------
  logic slow_reg;
  logic stall_reg;
  logic [rsseq_pkg::STALL_W-1:0] stall_cnt_reg;
  logic slow_req;
  logic do_switch;

  // A request made during a stall waits for it to end, so the two
  // stall periods never overlap
  assign slow_req = dual_speed & ~fast_sel_reg;
  assign do_switch = !core_reset_reg && (slow_req != slow_reg) && (stall_cnt_reg == '0);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_reg <= 1'b0;
      stall_reg <= 1'b0;
      stall_cnt_reg <= '0;
    end else if (core_reset_reg) begin
      slow_reg <= 1'b0;
      stall_reg <= 1'b0;
      stall_cnt_reg <= '0;
    end else if (do_switch) begin
      slow_reg <= slow_req;
      stall_reg <= 1'b1;
      if (slow_req) begin
        stall_cnt_reg <= rsseq_pkg::STALL_W'(rsseq_pkg::F2S_CYCLES);
      end else begin
        stall_cnt_reg <= rsseq_pkg::STALL_W'(rsseq_pkg::S2F_CYCLES);
      end
    end else begin
      stall_reg <= stall_cnt_reg > rsseq_pkg::STALL_W'(1);
      if (stall_cnt_reg != '0) begin
        stall_cnt_reg <= stall_cnt_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [rsseq_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= '0;
    end else if (!i_rd) begin
      rdata_reg <= '0;
    end else begin
      unique case (i_addr)
        rsseq_pkg::ADDR_PCS: rdata_reg <= {4'h0, fast_sel_reg, 1'b0, por_flag_reg, drop_flag_reg};
        rsseq_pkg::ADDR_CFG: rdata_reg <= cfg_reg;
        rsseq_pkg::ADDR_CAUSE: rdata_reg <= {2'h0, state_reg, cause_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  assign o_core_reset = core_reset_reg;
  assign o_core_stall = stall_reg;
  assign o_wake = wake_reg;
  assign o_slow_clock = slow_reg;
  assign o_drop_ctl = drop_ctl_reg;
  assign o_ext_pin_oe_n = pin_oe_n_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  logic [rsseq_pkg::STALL_W-1:0] stall_len_reg;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stall_len_reg <= '0;
    end else if (stall_reg) begin
      stall_len_reg <= stall_len_reg + 1'b1;
    end else begin
      stall_len_reg <= '0;
    end
  end

  sequence s_held_run;
    state_reg == rsseq_pkg::S_HOLD && pin_lvl && !por_pulse && !drop_trip;
  endsequence
  sequence s_released;
    state_reg == rsseq_pkg::S_RUN ##0 !o_core_reset;
  endsequence

  a_pin_not_driven: assert property (o_ext_pin_oe_n)
    else $error("Reset pin output enable asserted");
  a_stall_to_slow: assert property ($fell(o_core_stall) && !$past(o_core_reset)
      && o_slow_clock |-> stall_len_reg >= 1000 && stall_len_reg <= 3000)
    else $error("Fast to slow stall length out of range");
  a_stall_to_fast: assert property ($fell(o_core_stall) && !$past(o_core_reset)
      && !o_slow_clock |-> stall_len_reg >= 13 && stall_len_reg <= 32)
    else $error("Slow to fast stall length out of range");
  a_drop_flag_clr: assert property (drop_entry && !por_pulse |=> !drop_flag_reg)
    else $error("Drop flag not cleared on supply-drop reset");
  a_por_flag_clr: assert property (por_pulse |=> !por_flag_reg && drop_flag_reg)
    else $error("Power-on flags wrong after power-on reset");
  a_delay_holds: assert property (state_reg == rsseq_pkg::S_DELAY |-> o_core_reset)
    else $error("Core released during power-up delay");
  a_wdt_wake_keeps: assert property (state_reg == rsseq_pkg::S_RUN && i_wdt_timeout
      && i_sleep && pin_lvl && !por_pulse && !drop_trip |=> !o_core_reset && $stable(por_flag_reg))
    else $error("Watchdog wake disturbed state");
  a_rc_no_timeout: assert property (por_pulse && cfg_reg.delay_en_n && !crystal |=>
      state_reg == rsseq_pkg::S_HOLD)
    else $error("Time-out inserted in RC mode with delay disabled");
  a_ost_crystal: assert property (state_reg == rsseq_pkg::S_OSC |-> crystal)
    else $error("Oscillator count outside crystal modes");
  a_pin_release: assert property (s_held_run |=> s_released)
    else $error("Pin release did not start execution at once");

endmodule

// ---- design/rsseq_pkg.sv ----
// Shared constants, types and timing for the reset and start-up sequencer
package rsseq_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_PCS = 2'h0;
  localparam logic [1:0] ADDR_CFG = 2'h1;
  localparam logic [1:0] ADDR_CAUSE = 2'h2;

  // ----------------------------------------------------------------
  // Power control and status fields
  // ----------------------------------------------------------------
  localparam int PCS_DROP_BIT = 0;
  localparam int PCS_POR_BIT = 1;
  localparam int PCS_FAST_BIT = 3;
  localparam logic [7:0] PCS_MASK = 8'h0b;
  localparam logic [7:0] PCS_RESET = 8'h09;

  // ----------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spare;
    logic [1:0] trip_sel;
    logic drop_en;
    logic delay_en_n;
    logic [2:0] osc_mode;
  } rsseq_cfg_s;

  localparam logic [7:0] CFG_RESET = 8'h11;
  localparam logic [2:0] MODE_EC = 3'h3;
  localparam int MODE_RC_BIT = 2;

  typedef struct packed {
    logic enable;
    logic [1:0] trip_sel;
  } rsseq_drop_ctl_s;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_POR, CAUSE_DROP, CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP, CAUSE_WDT, CAUSE_WDT_WAKE
  } rsseq_cause_e;

  typedef enum logic [2:0] {
    S_OFF, S_DROP, S_DELAY, S_OSC, S_HOLD, S_RUN, S_WAKE
  } rsseq_state_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int F2S_MIN_NS = 100000;
  localparam int F2S_MAX_NS = 300000;
  localparam int S2F_MIN_NS = 1250;
  localparam int S2F_MAX_NS = 3250;
  localparam int F2S_CYCLES = (F2S_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int F2S_MAX_CYCLES = F2S_MAX_NS / CLK_PERIOD_NS;
  localparam int S2F_CYCLES = (S2F_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int S2F_MAX_CYCLES = S2F_MAX_NS / CLK_PERIOD_NS;
  localparam int STALL_W = 12;

  localparam int DELAY_TICKS = 72;
  localparam int OST_CYCLES = 1024;
  localparam int DROP_MIN_CYCLES = 20;
  localparam int PIN_FILTER_CYCLES = 3;

endpackage

// ---- design/rsseq_sync_filter.sv ----
// Two-stage synchroniser followed by a persistence filter
`timescale 1ns/1ns
module rsseq_sync_filter #(
  parameter int FILTER_CYCLES = 1,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  if (FILTER_CYCLES < 1) begin : g_chk
    $error("FILTER_CYCLES must be at least 1");
  end

  logic meta_reg;
  logic sync_reg;
  logic level_reg;
  logic [CW-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Filter: a new level must persist before it is passed on
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_reg <= RESET_LEVEL;
      cnt_reg <= '0;
    end else if (sync_reg == level_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(FILTER_CYCLES - 1)) begin
      level_reg <= sync_reg;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign o_level = level_reg;

endmodule

// ---- verif/rsseq_far_model.sv ----
// Model of the supply monitors, reset pin and oscillator sources
`timescale 1ns/1ns
module rsseq_far_model #(
  parameter int RC_DIV = 4,
  parameter int OSC_DIV = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_por_on,
  input wire logic i_dip,
  input wire logic i_pin_low,
  output logic o_por_detect,
  output logic o_supply_below_trip,
  output logic o_ext_reset_pin,
  output logic o_rc_tick,
  output logic o_osc_tick
);
  int rc_cnt = 0;
  int osc_cnt = 0;
  // ----------------------------------------------------------------
  // Analog levels, no synchronisation here on purpose
  // ----------------------------------------------------------------
  assign o_por_detect = i_por_on;
  assign o_supply_below_trip = i_dip;
  assign o_ext_reset_pin = ~i_pin_low;
  // ----------------------------------------------------------------
  // Free running tick sources, slower than the system clock
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
    osc_cnt <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
    o_rc_tick <= (rc_cnt == RC_DIV - 1);
    o_osc_tick <= (osc_cnt == OSC_DIV - 1);
  end
endmodule

// ---- verif/rsseq_top_tb.sv ----
// Self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rsseq_top_tb;
  localparam int DT = 4;
  localparam int OC = 8;
  typedef struct {logic [1:0] addr; logic [7:0] exp;} rsseq_row_s;
  rsseq_row_s rows [4] = '{'{2'h0, 8'h09}, '{2'h1, 8'h11}, '{2'h2, 8'h00}, '{2'h3, 8'h00}};
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_wdt_timeout = 1'b0;
  logic i_sleep = 1'b0;
  logic por_on = 1'b0;
  logic dip = 1'b0;
  logic pin_low = 1'b0;
  logic por_det, below, pin, rc_tick, osc_tick;
  logic [7:0] o_rdata;
  logic o_core_reset, o_core_stall, o_wake, o_slow_clock, o_ext_pin_oe_n;
  rsseq_pkg::rsseq_drop_ctl_s o_drop_ctl;
  int num_errors = 0;
  int checked = 0;
  int n;
  always #50 i_ref_clk = ~i_ref_clk;
  rsseq_far_model u_far (.i_ref_clk(i_ref_clk), .i_por_on(por_on), .i_dip(dip),
    .i_pin_low(pin_low), .o_por_detect(por_det), .o_supply_below_trip(below),
    .o_ext_reset_pin(pin), .o_rc_tick(rc_tick), .o_osc_tick(osc_tick));
  rsseq_top #(.DELAY_TICKS(DT), .OST_CYCLES(OC), .DROP_MIN_CYCLES(2),
    .PIN_FILTER_CYCLES(2)) u_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_por_detect(por_det), .i_supply_below_trip(below), .i_ext_reset_pin(pin),
    .i_wdt_timeout(i_wdt_timeout), .i_sleep(i_sleep), .i_rc_tick(rc_tick),
    .i_osc_tick(osc_tick), .o_core_reset(o_core_reset), .o_core_stall(o_core_stall),
    .o_wake(o_wake), .o_slow_clock(o_slow_clock), .o_drop_ctl(o_drop_ctl),
    .o_ext_pin_oe_n(o_ext_pin_oe_n));
  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // Bounded wait so a stuck sequencer returns with cnt at lim, not a hang
  task automatic wait_rst(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (o_core_reset !== v && cnt < lim) begin
      @(posedge i_ref_clk);
      #1 cnt++;
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic stall_len(output int cnt);
    cnt = 0;
    for (int i = 0; i < 5 && o_core_stall !== 1'b1; i++) cycles(1);
    while (o_core_stall === 1'b1 && cnt < 2000) begin
      cycles(1);
      cnt++;
    end
  endtask
  task automatic conclude();
    $display("tests done: %0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    num_errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].addr, d);
      `CHK(d, rows[i].exp)
    end
    $display("test register reset values done");
    por_on <= 1'b1;
    wait_rst(1'b0, 400, n);
    `CHK(n >= (DT - 1) * 4 + (OC - 1) * 2, 1'b1)
    rd(rsseq_pkg::ADDR_PCS, d);
    `CHK(d, 8'h09)
    $display("test crystal power-on done");
    wr(rsseq_pkg::ADDR_PCS, 8'h0b);
    @(posedge i_ref_clk) dip <= 1'b1;
    @(posedge i_ref_clk) dip <= 1'b0;
    cycles(8);
    `CHK(o_core_reset, 1'b0)
    @(posedge i_ref_clk) dip <= 1'b1;
    cycles(10);
    `CHK(o_core_reset, 1'b1)
    dip <= 1'b0;
    cycles(10);
    dip <= 1'b1;
    cycles(10);
    dip <= 1'b0;
    wait_rst(1'b0, 400, n);
    `CHK(n >= (DT - 1) * 4 + (OC - 1) * 2, 1'b1)
    rd(rsseq_pkg::ADDR_PCS, d);
    `CHK(d, 8'h0a)
    $display("test supply drop done");
    @(posedge i_ref_clk) pin_low <= 1'b1;
    @(posedge i_ref_clk) pin_low <= 1'b0;
    cycles(8);
    `CHK(o_core_reset, 1'b0)
    @(posedge i_ref_clk) pin_low <= 1'b1;
    cycles(8);
    `CHK(o_core_reset, 1'b1)
    pin_low <= 1'b0;
    wait_rst(1'b0, 12, n);
    `CHK(n <= 8, 1'b1)
    $display("test pin reset done");
    @(posedge i_ref_clk) i_wdt_timeout <= 1'b1;
    @(posedge i_ref_clk) i_wdt_timeout <= 1'b0;
    #1;
    `CHK(o_core_reset, 1'b1)
    `CHK(o_ext_pin_oe_n, 1'b1)
    wait_rst(1'b0, 12, n);
    `CHK(n <= 2, 1'b1)
    rd(rsseq_pkg::ADDR_CAUSE, d);
    `CHK(d, 8'h2d)
    $display("test watchdog reset done");
    wr(rsseq_pkg::ADDR_PCS, 8'h03);
    cycles(6);
    `CHK(o_slow_clock, 1'b0)
    // Enter resistor mode at the normal rate, so the stall starts on the request
    wr(rsseq_pkg::ADDR_PCS, 8'h0b);
    wr(rsseq_pkg::ADDR_CFG, 8'h16);
    wr(rsseq_pkg::ADDR_PCS, 8'h03);
    stall_len(n);
    `CHK(n, 1000)
    `CHK(o_slow_clock, 1'b1)
    wr(rsseq_pkg::ADDR_PCS, 8'h0b);
    stall_len(n);
    `CHK(n, 13)
    `CHK(o_slow_clock, 1'b0)
    $display("test speed switch done");
    @(posedge i_ref_clk) i_sleep <= 1'b1;
    i_wdt_timeout <= 1'b1;
    @(posedge i_ref_clk) i_wdt_timeout <= 1'b0;
    #1;
    `CHK(o_wake, 1'b1)
    `CHK(o_core_reset, 1'b0)
    cycles(1);
    `CHK(o_wake, 1'b0)
    @(posedge i_ref_clk) i_sleep <= 1'b0;
    $display("test watchdog wake done");
    wr(rsseq_pkg::ADDR_CFG, 8'h1c);
    por_on <= 1'b0;
    cycles(5);
    por_on <= 1'b1;
    wait_rst(1'b1, 8, n);
    wait_rst(1'b0, 8, n);
    `CHK(n <= 3, 1'b1)
    $display("test rc power-on without delay done");
    wr(rsseq_pkg::ADDR_CFG, 8'h11);
    pin_low <= 1'b1;
    por_on <= 1'b0;
    cycles(5);
    por_on <= 1'b1;
    cycles(300);
    `CHK(o_core_reset, 1'b1)
    pin_low <= 1'b0;
    wait_rst(1'b0, 12, n);
    `CHK(n <= 8, 1'b1)
    `CHK(o_drop_ctl, 3'h4)
    $display("test held pin power-on done");
    conclude();
  end
endmodule
